// ===== rtl/srs_defines.vh
/*
 * Constants for the supply reset and oscillator select block: register
 * indices, bank slots, field positions, reset values and bus widths.
 * Assumes it is included by its bare name from the rtl/ files.
 */
`ifndef SRS_DEFINES_VH
`define SRS_DEFINES_VH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define SRS_ADDR_W 26
`define SRS_INDEX_W 24

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SRS_IDX_DEVCFG 24'h000880
`define SRS_IDX_DEVICE_CLASS_ID 24'h000882
`define SRS_IDX_SILICON_REVISION_ID 24'h000883
`define SRS_IDX_BROWNOUT_CONFIG 24'h000985
`define SRS_IDX_CLKOUT 24'h007010
`define SRS_IDX_PLLSTAT 24'h007011
`define SRS_IDX_CLKSRC 24'h007012
`define SRS_IDX_LOCKPRD 24'h007013
`define SRS_IDX_TRIM1 24'h007014
`define SRS_IDX_TRIM2 24'h007016
`define SRS_IDX_PCLK2 24'h007019
`define SRS_IDX_PRESCL 24'h00701B
`define SRS_IDX_PCLK0 24'h00701C
`define SRS_IDX_PCLK1 24'h00701D
`define SRS_IDX_SLEEP 24'h00701E
`define SRS_IDX_PCLK3 24'h007020
`define SRS_IDX_PLLRATIO 24'h007021
`define SRS_IDX_SYSSTAT 24'h007022
`define SRS_IDX_WDCOUNT 24'h007023
`define SRS_IDX_WATCHDOG_SERVICE_KEY 24'h007025
`define SRS_IDX_WDCTRL 24'h007029
`define SRS_IDX_PART_IDENTIFIER 24'h3D7E80

// ****************************************************************
// Writable bank slots
// ****************************************************************
`define SRS_NSLOT 18
`define SRS_SLOT_W 5
`define SRS_SLOT_NONE 5'h1F
`define SRS_SLOT_DEVCFG 5'h00
`define SRS_SLOT_BROWNOUT_CONFIG 5'h01
`define SRS_SLOT_CLKOUT 5'h02
`define SRS_SLOT_PLLSTAT 5'h03
`define SRS_SLOT_CLKSRC 5'h04
`define SRS_SLOT_LOCKPRD 5'h05
`define SRS_SLOT_TRIM1 5'h06
`define SRS_SLOT_TRIM2 5'h07
`define SRS_SLOT_PCLK2 5'h08
`define SRS_SLOT_PRESCL 5'h09
`define SRS_SLOT_PCLK0 5'h0A
`define SRS_SLOT_PCLK1 5'h0B
`define SRS_SLOT_SLEEP 5'h0C
`define SRS_SLOT_PCLK3 5'h0D
`define SRS_SLOT_PLLRATIO 5'h0E
`define SRS_SLOT_SYSSTAT 5'h0F
`define SRS_SLOT_WATCHDOG_SERVICE_KEY 5'h10
`define SRS_SLOT_WDCTRL 5'h11

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define SRS_BOR_DISABLE_BIT 0
`define SRS_CLK_SELECT_BIT 0
`define SRS_OSC1_OFF_BIT 1
`define SRS_OSC2_OFF_BIT 2
`define SRS_PLL_LOCK_BIT 0
`define SRS_TRIM_W 16
`define SRS_WIDE_MASK 32'hFFFFFFFF
`define SRS_NARROW_MASK 32'h0000FFFF
`define SRS_RESET_VALUE 32'h00000000

`endif

// ===== rtl/srs_sync.v
/*
 * Two flip-flop synchroniser for a vector of unrelated levels.
 * Assumes each bit is an independent level; no bus coherence is given.
 */
`timescale 1ns/1ps

module srs_sync #(
	parameter WIDTH = 6
) (
	input wire clk, // System clock
	input wire rst, // Synchronous reset, active high
	input wire [WIDTH-1:0] asyncIn, // Levels from outside the domain
	output reg [WIDTH-1:0] syncOut // Levels safe to use
);

	reg [WIDTH-1:0] meta_reg;

	// ****************************************************************
	// Two stages; first stage feeds only the second
	// ****************************************************************
	always @(posedge clk) begin
		if (rst) begin
			meta_reg <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= asyncIn;
			syncOut <= meta_reg;
		end
	end

endmodule

// ===== rtl/srs_top.v
/*
 * Supply reset and oscillator select: supervisor reset pin drive, internal
 * reset combining, oscillator enables, trims and clock select, and the
 * write-protected system-control register bank on an APB slave.
 * Assumes one 10 MHz clock, a synchronous active-high reset that acts as
 * power-on reset, supply comparators and pins arriving asynchronously, and
 * unlock/lock, watchdog, debugger and missing-clock pulses on this clock.
 */
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "srs_defines.vh"

module srs_top #(
	parameter [15:0] CLASS_ID = 16'h00A5, // Arbitrary value
	parameter [15:0] REV_ID = 16'h0007, // Arbitrary value
	parameter [15:0] PART_ID = 16'h005A // Arbitrary value
) (
	input wire clk, // System clock, 10 MHz
	input wire rst, // Power-on reset, synchronous, active high
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [`SRS_ADDR_W-1:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output wire pready, // APB ready
	output reg [31:0] prdata, // APB read data
	output wire pslverr, // APB error, unmapped address
	input wire porCoreLow, // Core rail under power-on trip
	input wire porIoLow, // I/O rail under power-on trip
	input wire borCoreLow, // Core rail under brown-out trip
	input wire borIoLow, // I/O rail under brown-out trip
	input wire regulatorDisablePin, // High disables the internal regulator
	input wire extResetPinIn, // External reset pin level, low is reset
	output wire extResetPinOut, // Pin drive value, always low
	output reg extResetPinOeN, // Pin output enable, low while driving
	input wire watchdogReset, // Watchdog reset pulse or level
	input wire debugReset, // Debugger reset
	input wire missingClockReset, // Missing-clock detector reset
	input wire protectedWriteUnlock, // Unlock pulse from the CPU
	input wire protectedWriteLock, // Lock pulse from the CPU
	input wire pllLocked, // PLL lock indication
	input wire [15:0] watchdogCount, // Live watchdog counter value
	input wire cpuInputClockEn, // CPU input clock enable pulse
	output wire systemClockOutputEn, // System clock output enable pulse
	output reg deviceReset, // Internal device reset
	output reg supplyMonitorReset, // Supervisor reset
	output reg oscOneEnable, // First internal oscillator powered
	output reg oscTwoEnable, // Second internal oscillator powered
	output reg oscSelect, // 0 first oscillator, 1 second
	output reg [`SRS_TRIM_W-1:0] oscOneTrim, // First oscillator trim
	output reg [`SRS_TRIM_W-1:0] oscTwoTrim, // Second oscillator trim
	output reg writeUnlocked // Protected writes currently allowed
);

	// ****************************************************************
	// Address decode helpers
	// ****************************************************************

	// Maps a register index to its writable slot, or none
	function [`SRS_SLOT_W-1:0] slotOf;
		input [`SRS_INDEX_W-1:0] idx;
		begin
			case (idx)
				`SRS_IDX_DEVCFG: slotOf = `SRS_SLOT_DEVCFG;
				`SRS_IDX_BROWNOUT_CONFIG: slotOf = `SRS_SLOT_BROWNOUT_CONFIG;
				`SRS_IDX_CLKOUT: slotOf = `SRS_SLOT_CLKOUT;
				`SRS_IDX_PLLSTAT: slotOf = `SRS_SLOT_PLLSTAT;
				`SRS_IDX_CLKSRC: slotOf = `SRS_SLOT_CLKSRC;
				`SRS_IDX_LOCKPRD: slotOf = `SRS_SLOT_LOCKPRD;
				`SRS_IDX_TRIM1: slotOf = `SRS_SLOT_TRIM1;
				`SRS_IDX_TRIM2: slotOf = `SRS_SLOT_TRIM2;
				`SRS_IDX_PCLK2: slotOf = `SRS_SLOT_PCLK2;
				`SRS_IDX_PRESCL: slotOf = `SRS_SLOT_PRESCL;
				`SRS_IDX_PCLK0: slotOf = `SRS_SLOT_PCLK0;
				`SRS_IDX_PCLK1: slotOf = `SRS_SLOT_PCLK1;
				`SRS_IDX_SLEEP: slotOf = `SRS_SLOT_SLEEP;
				`SRS_IDX_PCLK3: slotOf = `SRS_SLOT_PCLK3;
				`SRS_IDX_PLLRATIO: slotOf = `SRS_SLOT_PLLRATIO;
				`SRS_IDX_SYSSTAT: slotOf = `SRS_SLOT_SYSSTAT;
				`SRS_IDX_WATCHDOG_SERVICE_KEY: slotOf = `SRS_SLOT_WATCHDOG_SERVICE_KEY;
				`SRS_IDX_WDCTRL: slotOf = `SRS_SLOT_WDCTRL;
				default: slotOf = `SRS_SLOT_NONE;
			endcase
		end
	endfunction

	// True for read-only identity and counter indices
	function isReadOnly;
		input [`SRS_INDEX_W-1:0] idx;
		begin
			isReadOnly = (idx == `SRS_IDX_DEVICE_CLASS_ID) || (idx == `SRS_IDX_SILICON_REVISION_ID) ||
				(idx == `SRS_IDX_PART_IDENTIFIER) || (idx == `SRS_IDX_WDCOUNT);
		end
	endfunction

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	wire [5:0] pinSync;
	wire porCoreS;
	wire porIoS;
	wire borCoreS;
	wire borIoS;
	wire regDisableS;
	wire extResetLowS;

	// Pin level is inverted first so the synchroniser's reset value of 0 reads idle
	srs_sync #(
		.WIDTH(6)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.asyncIn({~extResetPinIn, regulatorDisablePin, borIoLow, borCoreLow, porIoLow,
			porCoreLow}),
		.syncOut(pinSync)
	);

	assign porCoreS = pinSync[0];
	assign porIoS = pinSync[1];
	assign borCoreS = pinSync[2];
	assign borIoS = pinSync[3];
	assign regDisableS = pinSync[4];
	assign extResetLowS = pinSync[5];

	// ****************************************************************
	// Reset domains
	// ****************************************************************
	wire pllDomainReset;
	wire bankReset;

	// PLL registers survive debugger and missing-clock resets
	assign pllDomainReset = rst | extResetLowS | watchdogReset;
	assign bankReset = pllDomainReset | debugReset | missingClockReset;

	// ****************************************************************
	// Register bank storage
	// ****************************************************************
	reg [31:0] bank_reg [0:`SRS_NSLOT-1];
	wire [`SRS_INDEX_W-1:0] accessIndex;
	wire [`SRS_SLOT_W-1:0] accessSlot;
	wire writeStrobe;
	wire writeAllowed;

	assign accessIndex = paddr[`SRS_ADDR_W-1:2];
	assign accessSlot = slotOf(accessIndex);
	assign writeStrobe = psel & penable & pwrite & (accessSlot != `SRS_SLOT_NONE);
	// Every writable slot is protected; a stray pointer cannot reach them
	assign writeAllowed = writeStrobe & writeUnlocked;

	// One process per slot, each with its own reset domain and width
	genvar s;
	generate
		for (s = 0; s < `SRS_NSLOT; s = s + 1) begin : g_slot
			localparam [`SRS_SLOT_W-1:0] SLOT = s;
			localparam IS_PLL = (SLOT == `SRS_SLOT_PLLSTAT) ||
				(SLOT == `SRS_SLOT_PLLRATIO);
			localparam [31:0] MASK = (SLOT == `SRS_SLOT_DEVCFG) ?
				`SRS_WIDE_MASK : `SRS_NARROW_MASK;
			wire slotReset;
			assign slotReset = IS_PLL ? pllDomainReset : bankReset;
			always @(posedge clk) begin
				if (slotReset) begin
					bank_reg[s] <= `SRS_RESET_VALUE;
				end else if (writeAllowed && accessSlot == SLOT) begin
					bank_reg[s] <= pwdata & MASK;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Protected-write state
	// ****************************************************************

	// Lock wins over unlock when both arrive together, the safer outcome
	always @(posedge clk) begin
		if (bankReset) begin
			writeUnlocked <= 1'b0;
		end else if (protectedWriteLock) begin
			writeUnlocked <= 1'b0;
		end else if (protectedWriteUnlock) begin
			writeUnlocked <= 1'b1;
		end
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************

	// Zero wait states; read data is captured during the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & (accessSlot == `SRS_SLOT_NONE) &
		~isReadOnly(accessIndex);

	always @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			if (accessSlot == `SRS_SLOT_PLLSTAT) begin
				prdata <= {bank_reg[accessSlot][31:1], pllLocked};
			end else if (accessSlot != `SRS_SLOT_NONE) begin
				prdata <= bank_reg[accessSlot];
			end else begin
				case (accessIndex)
					`SRS_IDX_DEVICE_CLASS_ID: prdata <= {16'h0000, CLASS_ID};
					`SRS_IDX_SILICON_REVISION_ID: prdata <= {16'h0000, REV_ID};
					`SRS_IDX_PART_IDENTIFIER: prdata <= {16'h0000, PART_ID};
					`SRS_IDX_WDCOUNT: prdata <= {16'h0000, watchdogCount};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ****************************************************************
	// Supply supervision
	// ****************************************************************
	reg borArmed;
	wire borDisable;
	wire porTrip;
	wire borTrip;
	wire supervisorTrip;

	// Brown-out counts once both synchronised power-on trips read clear, which the sync reset value makes the first cycle after reset
	always @(posedge clk) begin
		if (rst) begin
			borArmed <= 1'b0;
		end else if (!porCoreS && !porIoS) begin
			borArmed <= 1'b1;
		end
	end

	assign borDisable = bank_reg[`SRS_SLOT_BROWNOUT_CONFIG][`SRS_BOR_DISABLE_BIT];
	assign porTrip = porCoreS | porIoS;
	// Core brown-out is ignored while the regulator is off
	assign borTrip = borArmed & ~borDisable & (borIoS | (borCoreS & ~regDisableS));
	assign supervisorTrip = porTrip | borTrip;

	// Open-drain pin: value is always low, only the enable moves
	assign extResetPinOut = 1'b0;

	always @(posedge clk) begin
		if (rst) begin
			extResetPinOeN <= 1'b1;
			supplyMonitorReset <= 1'b0;
			deviceReset <= 1'b1;
		end else begin
			extResetPinOeN <= ~supervisorTrip;
			supplyMonitorReset <= supervisorTrip;
			deviceReset <= extResetLowS | watchdogReset | supervisorTrip;
		end
	end

	// ****************************************************************
	// Oscillator control
	// ****************************************************************

	// Register reset of zero means both running and the first selected
	always @(posedge clk) begin
		if (rst) begin
			oscOneEnable <= 1'b1;
			oscTwoEnable <= 1'b1;
			oscSelect <= 1'b0;
			oscOneTrim <= {`SRS_TRIM_W{1'b0}};
			oscTwoTrim <= {`SRS_TRIM_W{1'b0}};
		end else begin
			oscOneEnable <= ~bank_reg[`SRS_SLOT_CLKSRC][`SRS_OSC1_OFF_BIT];
			oscTwoEnable <= ~bank_reg[`SRS_SLOT_CLKSRC][`SRS_OSC2_OFF_BIT];
			oscSelect <= bank_reg[`SRS_SLOT_CLKSRC][`SRS_CLK_SELECT_BIT];
			oscOneTrim <= bank_reg[`SRS_SLOT_TRIM1][`SRS_TRIM_W-1:0];
			oscTwoTrim <= bank_reg[`SRS_SLOT_TRIM2][`SRS_TRIM_W-1:0];
		end
	end

	// ****************************************************************
	// System clock output
	// ****************************************************************

	// Straight pass so the output rate can never drift from the input rate
	assign systemClockOutputEn = cpuInputClockEn;

endmodule

// ===== verif/srs_top_assertions.sv
/*
 * Checker for srs_top: supervisor pin drive, oscillator defaults, clock
 * pass-through, write lock and trim relations.
 * Assumes it is bound to srs_top, one clock, rst synchronous active high.
 */
`timescale 1ns/1ps
`include "srs_defines.vh"

module srs_top_assertions (
	input wire clk, // System clock
	input wire rst, // Reset, active high
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [`SRS_ADDR_W-1:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	input wire porCoreLow, // Core power-on trip
	input wire porIoLow, // I/O power-on trip
	input wire borCoreLow, // Core brown-out trip
	input wire borIoLow, // I/O brown-out trip
	input wire regulatorDisablePin, // Regulator off when high
	input wire extResetPinOeN, // Pin drive enable, low drives
	input wire watchdogReset, // Watchdog reset
	input wire debugReset, // Debugger reset
	input wire missingClockReset, // Missing-clock reset
	input wire protectedWriteLock, // Lock pulse
	input wire cpuInputClockEn, // CPU clock enable in
	input wire systemClockOutputEn, // System clock enable out
	input wire deviceReset, // Internal reset
	input wire supplyMonitorReset, // Supervisor reset
	input wire oscOneEnable, // First oscillator on
	input wire oscTwoEnable, // Second oscillator on
	input wire oscSelect, // Clock source select
	input wire [15:0] oscOneTrim, // First oscillator trim
	input wire writeUnlocked // Protected writes allowed
);
	// ****************************************************************
	// Helper terms and properties
	// ****************************************************************
	// No bank reset around the write, else a cleared trim would look like a fault
	wire quiet = !debugReset && !missingClockReset && !watchdogReset && !deviceReset;
	wire trimWr = psel && penable && pwrite && paddr[25:2] == `SRS_IDX_TRIM1 && quiet;
	wire [15:0] pwLow = pwdata[15:0];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Trip inputs pass two sync stages and one output stage
	a_pin_supply: assert property (
		porIoLow[*3] |=> !extResetPinOeN && supplyMonitorReset && deviceReset)
		else $error("Reset pin not pulled on I/O trip");
	a_por_core: assert property (
		(porCoreLow && regulatorDisablePin)[*3] |=> supplyMonitorReset)
		else $error("Core power-on trip ignored");
	a_bor_core_off: assert property (
		(borCoreLow && regulatorDisablePin && !porCoreLow && !porIoLow && !borIoLow)[*3]
		|=> !supplyMonitorReset)
		else $error("Core brown-out active with regulator off");
	a_osc_defaults: assert property (
		$fell(rst) |-> oscOneEnable && oscTwoEnable && !oscSelect)
		else $error("Oscillator defaults wrong at reset");
	a_sysclk_same: assert property (
		systemClockOutputEn == cpuInputClockEn)
		else $error("System clock enable differs from input");
	a_lock_closes: assert property (
		protectedWriteLock |=> !writeUnlocked)
		else $error("Lock did not close writes");
	a_locked_write: assert property (
		trimWr && !writeUnlocked |=> ##1 $stable(oscOneTrim))
		else $error("Locked write changed trim");
	a_trim_follows: assert property (
		trimWr && writeUnlocked |=> ##1 oscOneTrim == $past(pwLow, 2))
		else $error("Trim output does not follow register");
	a_wd_resets: assert property (
		watchdogReset |=> deviceReset)
		else $error("Watchdog reset not seen on device reset");
endmodule

bind srs_top srs_top_assertions u_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.porCoreLow(porCoreLow), .porIoLow(porIoLow), .borCoreLow(borCoreLow),
	.borIoLow(borIoLow), .regulatorDisablePin(regulatorDisablePin),
	.extResetPinOeN(extResetPinOeN), .watchdogReset(watchdogReset),
	.debugReset(debugReset), .missingClockReset(missingClockReset),
	.protectedWriteLock(protectedWriteLock), .cpuInputClockEn(cpuInputClockEn),
	.systemClockOutputEn(systemClockOutputEn), .deviceReset(deviceReset),
	.supplyMonitorReset(supplyMonitorReset), .oscOneEnable(oscOneEnable),
	.oscTwoEnable(oscTwoEnable), .oscSelect(oscSelect), .oscOneTrim(oscOneTrim),
	.writeUnlocked(writeUnlocked));

// ===== verif/tb_srs_top.sv
/*
 * Self-checking bench for srs_top: register table, lock, oscillators,
 * PLL reset sources and supervisors.
 * Assumes default identity parameters and the APB timing of the hand-over.
 */
`timescale 1ns/1ps
`include "srs_defines.vh"

module tb_srs_top;
	typedef struct {logic [23:0] idx; logic [31:0] wd; logic [31:0] exp; logic err;} srs_row_t;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [`SRS_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic porCoreLow = 0, porIoLow = 0, borCoreLow = 0, borIoLow = 0, regulatorDisablePin = 0;
	logic pinDrv = 1, extResetPinIn, extResetPinOut, extResetPinOeN;
	logic watchdogReset = 0, debugReset = 0, missingClockReset = 0, cpuInputClockEn = 0;
	logic protectedWriteUnlock = 0, protectedWriteLock = 0, systemClockOutputEn;
	logic deviceReset, supplyMonitorReset, oscOneEnable, oscTwoEnable, oscSelect, writeUnlocked;
	logic [15:0] oscOneTrim, oscTwoTrim;
	int err_count = 0, checks = 0;
	// Write, expected read-back: low half only except the 32-bit word
	srs_row_t rows[14] = '{
		'{`SRS_IDX_DEVCFG, 32'hA5A51234, 32'hA5A51234, 1'b0},
		'{`SRS_IDX_BROWNOUT_CONFIG, 32'hFFFFFFFE, 32'h0000FFFE, 1'b0},
		'{`SRS_IDX_CLKOUT, 32'h12345678, 32'h00005678, 1'b0},
		'{`SRS_IDX_LOCKPRD, 32'h0000ABCD, 32'h0000ABCD, 1'b0},
		'{`SRS_IDX_TRIM1, 32'h00001357, 32'h00001357, 1'b0},
		'{`SRS_IDX_TRIM2, 32'h00002468, 32'h00002468, 1'b0},
		'{`SRS_IDX_PCLK0, 32'hFFFF0F0F, 32'h00000F0F, 1'b0},
		'{`SRS_IDX_SLEEP, 32'h00000042, 32'h00000042, 1'b0},
		'{`SRS_IDX_PLLSTAT, 32'h00000000, 32'h00000001, 1'b0},
		'{`SRS_IDX_WDCOUNT, 32'h00001111, 32'h0000BEEF, 1'b0},
		'{`SRS_IDX_DEVICE_CLASS_ID, 32'hFFFFFFFF, 32'h000000A5, 1'b0},
		'{`SRS_IDX_SILICON_REVISION_ID, 32'hFFFFFFFF, 32'h00000007, 1'b0},
		'{`SRS_IDX_PART_IDENTIFIER, 32'hFFFFFFFF, 32'h0000005A, 1'b0},
		'{24'h007024, 32'h0000FFFF, 32'h00000000, 1'b1}};

	// Pin wire: low while the block drives it, else the outside level
	assign extResetPinIn = extResetPinOeN ? pinDrv : extResetPinOut;

	srs_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.porCoreLow(porCoreLow), .porIoLow(porIoLow), .borCoreLow(borCoreLow),
		.borIoLow(borIoLow), .regulatorDisablePin(regulatorDisablePin),
		.extResetPinIn(extResetPinIn), .extResetPinOut(extResetPinOut),
		.extResetPinOeN(extResetPinOeN), .watchdogReset(watchdogReset),
		.debugReset(debugReset), .missingClockReset(missingClockReset),
		.protectedWriteUnlock(protectedWriteUnlock), .protectedWriteLock(protectedWriteLock),
		.pllLocked(1'b1), .watchdogCount(16'hBEEF), .cpuInputClockEn(cpuInputClockEn),
		.systemClockOutputEn(systemClockOutputEn), .deviceReset(deviceReset),
		.supplyMonitorReset(supplyMonitorReset), .oscOneEnable(oscOneEnable),
		.oscTwoEnable(oscTwoEnable), .oscSelect(oscSelect), .oscOneTrim(oscOneTrim),
		.oscTwoTrim(oscTwoTrim), .writeUnlocked(writeUnlocked));

	// 10 MHz clock and a toggling CPU clock enable
	always #50 clk = ~clk;
	always @(posedge clk) cpuInputClockEn <= ~cpuInputClockEn;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Setup then access; waits on pready since the slave sets the pace
	task apb(input logic w, input logic [23:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk);
		end
		if (n >= 50) begin
			err_count++;
			$display("wrong value at %0t: no pready", $time);
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task unlock;
		@(posedge clk) protectedWriteUnlock <= 1;
		@(posedge clk) protectedWriteUnlock <= 0;
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk(32'({oscOneEnable, oscTwoEnable, oscSelect}), 32'h6, "osc defaults");
		$display("test reset done");
		unlock();
		foreach (rows[i]) begin
			apb(1, rows[i].idx, rows[i].wd);
			apb(0, rows[i].idx, 32'h0);
			chk(rd, rows[i].exp, "read back");
			chk(32'(er), 32'(rows[i].err), "slave error");
		end
		chk(32'(oscOneTrim), 32'h1357, "trim one");
		chk(32'(oscTwoTrim), 32'h2468, "trim two");
		chk(32'(writeUnlocked), 32'h1, "unlocked");
		chk(32'(extResetPinOut), 32'h0, "pin drive low");
		$display("test register table done");
		// Locked writes must leave the trim alone
		@(posedge clk) protectedWriteLock <= 1;
		@(posedge clk) protectedWriteLock <= 0;
		apb(1, `SRS_IDX_TRIM1, 32'h0000FFFF);
		apb(0, `SRS_IDX_TRIM1, 32'h0);
		chk(rd, 32'h1357, "locked write");
		chk(32'(writeUnlocked), 32'h0, "locked");
		$display("test lock done");
		// Clock source select and oscillator power-down
		unlock();
		apb(1, `SRS_IDX_CLKSRC, 32'h3);
		repeat (2) @(posedge clk);
		chk(32'({oscSelect, oscOneEnable, oscTwoEnable}), 32'h5, "second selected");
		apb(1, `SRS_IDX_CLKSRC, 32'h4);
		repeat (2) @(posedge clk);
		chk(32'({oscSelect, oscOneEnable, oscTwoEnable}), 32'h2, "second off");
		apb(1, `SRS_IDX_CLKSRC, 32'h0);
		$display("test oscillators done");
		// PLL ratio survives debugger and missing-clock resets only
		apb(1, `SRS_IDX_PLLRATIO, 32'h5);
		@(posedge clk) debugReset <= 1;
		@(posedge clk) debugReset <= 0;
		@(posedge clk) missingClockReset <= 1;
		@(posedge clk) missingClockReset <= 0;
		repeat (3) @(posedge clk);
		apb(0, `SRS_IDX_PLLRATIO, 32'h0);
		chk(rd, 32'h5, "ratio kept");
		@(posedge clk) watchdogReset <= 1;
		@(posedge clk) watchdogReset <= 0;
		repeat (3) @(posedge clk);
		apb(0, `SRS_IDX_PLLRATIO, 32'h0);
		chk(rd, 32'h0, "ratio cleared");
		$display("test pll reset done");
		// Supervisors; the pin loops back, so allow its sync to settle
		porIoLow <= 1;
		repeat (5) @(posedge clk);
		chk(32'({extResetPinOeN, supplyMonitorReset}), 32'h1, "io trip");
		porIoLow <= 0;
		repeat (8) @(posedge clk);
		chk(32'(extResetPinOeN), 32'h1, "pin released");
		borIoLow <= 1;
		repeat (5) @(posedge clk);
		chk(32'(supplyMonitorReset), 32'h1, "io brown-out");
		borIoLow <= 0;
		regulatorDisablePin <= 1;
		borCoreLow <= 1;
		repeat (8) @(posedge clk);
		chk(32'(supplyMonitorReset), 32'h0, "core brown-out off");
		regulatorDisablePin <= 0;
		repeat (5) @(posedge clk);
		chk(32'(supplyMonitorReset), 32'h1, "core brown-out on");
		borCoreLow <= 0;
		repeat (8) @(posedge clk);
		unlock();
		apb(1, `SRS_IDX_BROWNOUT_CONFIG, 32'h1);
		borIoLow <= 1;
		borCoreLow <= 1;
		repeat (5) @(posedge clk);
		chk(32'(supplyMonitorReset), 32'h0, "brown-out disabled");
		porCoreLow <= 1;
		regulatorDisablePin <= 1;
		repeat (5) @(posedge clk);
		chk(32'(supplyMonitorReset), 32'h1, "power-on still on");
		{porCoreLow, borIoLow, borCoreLow, regulatorDisablePin} <= 4'h0;
		repeat (8) @(posedge clk);
		pinDrv <= 0;
		repeat (5) @(posedge clk);
		chk(32'(deviceReset), 32'h1, "pin reset");
		pinDrv <= 1;
		repeat (8) @(posedge clk);
		$display("test supervisors done");
		print_verdict();
	end
endmodule
